// file: common/gpio_pkg.sv
// Constants shared by the general purpose port logic
package gpio_pkg;
   // Implemented pin counts per port
   localparam int PA_W = 8;
   localparam int PB_W = 4;
   localparam int PC_W = 2;
   localparam int REG_W = 8;
   localparam int ADDR_W = 4;

   // Data-memory register indices
   localparam logic [3:0] IDX_PA_DATA = 4'h0;
   localparam logic [3:0] IDX_PA_DIR  = 4'h1;
   localparam logic [3:0] IDX_PA_PU   = 4'h2;
   localparam logic [3:0] IDX_PA_WAKE = 4'h3;
   localparam logic [3:0] IDX_PB_DATA = 4'h4;
   localparam logic [3:0] IDX_PB_DIR  = 4'h5;
   localparam logic [3:0] IDX_PB_PU   = 4'h6;
   localparam logic [3:0] IDX_PC_DATA = 4'h7;
   localparam logic [3:0] IDX_PC_DIR  = 4'h8;
   localparam logic [3:0] IDX_PC_PU   = 4'h9;

   // Power-on values
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic [7:0] DIR_RST  = 8'hFF;
   localparam logic [7:0] PU_RST   = 8'h00;
   localparam logic [7:0] WAKE_RST = 8'h00;
   localparam logic [7:0] SYNC_RST = 8'hFF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Direction bit encoding
   localparam logic DIR_INPUT  = 1'b1;
   localparam logic DIR_OUTPUT = 1'b0;
endpackage

// file: logic/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
module pin_sync #(
   parameter int         W       = 8,
   parameter logic [7:0] RST_VAL = 8'hFF
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage is read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL[W-1:0];
         q    <= RST_VAL[W-1:0];
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// file: logic/port_slice.sv
// One port: output latch, direction, pull-high enable and pad drive
module port_slice #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         wr_data,
   input  wire logic         wr_dir,
   input  wire logic         wr_pu,
   input  wire logic [W-1:0] wdata,
   input  wire logic [W-1:0] od_en,
   output logic      [W-1:0] data,
   output logic      [W-1:0] dir,
   output logic      [W-1:0] pu,
   output logic      [W-1:0] pad_out,
   output logic      [W-1:0] pad_oe_n,
   output logic      [W-1:0] pad_pu
);
   // Output latch holds until the next write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data <= gpio_pkg::DATA_RST[W-1:0];
      end else if (wr_data) begin
         data <= wdata;
      end
   end

   // Direction, all inputs after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir <= gpio_pkg::DIR_RST[W-1:0];
      end else if (wr_dir) begin
         dir <= wdata;
      end
   end

   // Pull-high enables, cleared at reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pu <= gpio_pkg::PU_RST[W-1:0];
      end else if (wr_pu) begin
         pu <= wdata;
      end
   end

   // Pad drive; open-drain drives only a low level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_out  <= gpio_pkg::DATA_RST[W-1:0];
         pad_oe_n <= gpio_pkg::DIR_RST[W-1:0];
         pad_pu   <= gpio_pkg::PU_RST[W-1:0];
      end else begin
         pad_out  <= data;
         pad_oe_n <= dir | (od_en & data);
         pad_pu   <= pu & (dir | od_en);
      end
   end
endmodule

// file: logic/gpio_ports.sv
// General purpose ports A, B and C with pull-high and port A wake-up
// Function
// - Port read returns live synchronised levels of input pins
// - Output latch holds value until rewritten
// - A eight bits, B four, C two; rest zero
// - Per-pin pull-high enable, cleared at reset
// - Pull-high only for input or open-drain
// - Port A falling edge wakes halted core
// - Per-pin port A wake enable, reset zero
// - Wake needs GPIO input and halted core
// - Direction 1 input, 0 output; reads latch
// - All pins inputs after reset
module gpio_ports (
   input  wire logic                      CORE_CLK,
   input  wire logic                      RST,
   input  wire logic [gpio_pkg::ADDR_W-1:0] ADDR,
   input  wire logic                      WR_STB,
   input  wire logic [gpio_pkg::REG_W-1:0]  WR_DATA,
   input  wire logic                      RD_STB,
   output logic      [gpio_pkg::REG_W-1:0]  RD_DATA,
   input  wire logic                      HALTED,
   input  wire logic [gpio_pkg::PA_W-1:0]   PA_GPIO_SEL,
   input  wire logic [gpio_pkg::PA_W-1:0]   PA_NMOS,
   input  wire logic [gpio_pkg::PB_W-1:0]   PB_NMOS,
   input  wire logic [gpio_pkg::PC_W-1:0]   PC_NMOS,
   input  wire logic [gpio_pkg::PA_W-1:0]   PA_IN,
   output logic      [gpio_pkg::PA_W-1:0]   PA_OUT,
   output logic      [gpio_pkg::PA_W-1:0]   PA_OE_N,
   output logic      [gpio_pkg::PA_W-1:0]   PA_PU,
   input  wire logic [gpio_pkg::PB_W-1:0]   PB_IN,
   output logic      [gpio_pkg::PB_W-1:0]   PB_OUT,
   output logic      [gpio_pkg::PB_W-1:0]   PB_OE_N,
   output logic      [gpio_pkg::PB_W-1:0]   PB_PU,
   input  wire logic [gpio_pkg::PC_W-1:0]   PC_IN,
   output logic      [gpio_pkg::PC_W-1:0]   PC_OUT,
   output logic      [gpio_pkg::PC_W-1:0]   PC_OE_N,
   output logic      [gpio_pkg::PC_W-1:0]   PC_PU,
   output logic                           WAKE_REQ
);
   localparam int PA_W = gpio_pkg::PA_W;
   localparam int PB_W = gpio_pkg::PB_W;
   localparam int PC_W = gpio_pkg::PC_W;

   logic [PA_W-1:0] pa_sync;
   logic [PB_W-1:0] pb_sync;
   logic [PC_W-1:0] pc_sync;
   logic [PA_W-1:0] pa_prev;
   logic [PA_W-1:0] pa_data;
   logic [PA_W-1:0] pa_dir;
   logic [PA_W-1:0] pa_pu;
   logic [PB_W-1:0] pb_data;
   logic [PB_W-1:0] pb_dir;
   logic [PB_W-1:0] pb_pu;
   logic [PC_W-1:0] pc_data;
   logic [PC_W-1:0] pc_dir;
   logic [PC_W-1:0] pc_pu;
   logic [PA_W-1:0] wake_en;
   logic [PA_W-1:0] pa_fall;
   logic [PA_W-1:0] wake_armed;
   logic [PA_W-1:0] pa_view;
   logic [PB_W-1:0] pb_view;
   logic [PC_W-1:0] pc_view;
   logic [7:0]      next_rd_data;
   logic            next_wake;

   // Pin synchronisers; pins are asynchronous to the core
   pin_sync #(.W(PA_W), .RST_VAL(gpio_pkg::SYNC_RST)) u_sync_a (
      .clk (CORE_CLK),
      .rst (RST),
      .d   (PA_IN),
      .q   (pa_sync)
   );
   pin_sync #(.W(PB_W), .RST_VAL(gpio_pkg::SYNC_RST)) u_sync_b (
      .clk (CORE_CLK),
      .rst (RST),
      .d   (PB_IN),
      .q   (pb_sync)
   );
   pin_sync #(.W(PC_W), .RST_VAL(gpio_pkg::SYNC_RST)) u_sync_c (
      .clk (CORE_CLK),
      .rst (RST),
      .d   (PC_IN),
      .q   (pc_sync)
   );

   // Port register slices, narrower ports take the low write bits
   port_slice #(.W(PA_W)) u_port_a (
      .clk      (CORE_CLK),
      .rst      (RST),
      .wr_data  (WR_STB && ADDR == gpio_pkg::IDX_PA_DATA),
      .wr_dir   (WR_STB && ADDR == gpio_pkg::IDX_PA_DIR),
      .wr_pu    (WR_STB && ADDR == gpio_pkg::IDX_PA_PU),
      .wdata    (WR_DATA[PA_W-1:0]),
      .od_en    (PA_NMOS),
      .data     (pa_data),
      .dir      (pa_dir),
      .pu       (pa_pu),
      .pad_out  (PA_OUT),
      .pad_oe_n (PA_OE_N),
      .pad_pu   (PA_PU)
   );
   port_slice #(.W(PB_W)) u_port_b (
      .clk      (CORE_CLK),
      .rst      (RST),
      .wr_data  (WR_STB && ADDR == gpio_pkg::IDX_PB_DATA),
      .wr_dir   (WR_STB && ADDR == gpio_pkg::IDX_PB_DIR),
      .wr_pu    (WR_STB && ADDR == gpio_pkg::IDX_PB_PU),
      .wdata    (WR_DATA[PB_W-1:0]),
      .od_en    (PB_NMOS),
      .data     (pb_data),
      .dir      (pb_dir),
      .pu       (pb_pu),
      .pad_out  (PB_OUT),
      .pad_oe_n (PB_OE_N),
      .pad_pu   (PB_PU)
   );
   port_slice #(.W(PC_W)) u_port_c (
      .clk      (CORE_CLK),
      .rst      (RST),
      .wr_data  (WR_STB && ADDR == gpio_pkg::IDX_PC_DATA),
      .wr_dir   (WR_STB && ADDR == gpio_pkg::IDX_PC_DIR),
      .wr_pu    (WR_STB && ADDR == gpio_pkg::IDX_PC_PU),
      .wdata    (WR_DATA[PC_W-1:0]),
      .od_en    (PC_NMOS),
      .data     (pc_data),
      .dir      (pc_dir),
      .pu       (pc_pu),
      .pad_out  (PC_OUT),
      .pad_oe_n (PC_OE_N),
      .pad_pu   (PC_PU)
   );

   // Port A wake enables
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         wake_en <= gpio_pkg::WAKE_RST;
      end else if (WR_STB && ADDR == gpio_pkg::IDX_PA_WAKE) begin
         wake_en <= WR_DATA;
      end
   end

   // Read view: input pins show the pin, outputs show the latch
   assign pa_view = (pa_dir & pa_sync) | (~pa_dir & pa_data);
   assign pb_view = (pb_dir & pb_sync) | (~pb_dir & pb_data);
   assign pc_view = (pc_dir & pc_sync) | (~pc_dir & pc_data);

   // Read mux; unimplemented high bits return zero
   always_comb begin
      next_rd_data = gpio_pkg::READ_UNMAPPED;
      unique case (ADDR)
         gpio_pkg::IDX_PA_DATA: next_rd_data = pa_view;
         gpio_pkg::IDX_PA_DIR:  next_rd_data = pa_dir;
         gpio_pkg::IDX_PA_PU:   next_rd_data = pa_pu;
         gpio_pkg::IDX_PA_WAKE: next_rd_data = wake_en;
         gpio_pkg::IDX_PB_DATA: next_rd_data = {4'h0, pb_view};
         gpio_pkg::IDX_PB_DIR:  next_rd_data = {4'h0, pb_dir};
         gpio_pkg::IDX_PB_PU:   next_rd_data = {4'h0, pb_pu};
         gpio_pkg::IDX_PC_DATA: next_rd_data = {6'h00, pc_view};
         gpio_pkg::IDX_PC_DIR:  next_rd_data = {6'h00, pc_dir};
         gpio_pkg::IDX_PC_PU:   next_rd_data = {6'h00, pc_pu};
         default:               next_rd_data = gpio_pkg::READ_UNMAPPED;
      endcase
   end

   // Read data captured on the strobe edge and held until the next read
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RD_DATA <= gpio_pkg::READ_UNMAPPED;
      end else if (RD_STB) begin
         RD_DATA <= next_rd_data;
      end
   end

   // Previous synchronised level for falling-edge detection
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         pa_prev <= gpio_pkg::SYNC_RST;
      end else begin
         pa_prev <= pa_sync;
      end
   end

   // Wake qualified by GPIO input selection and halted core
   assign pa_fall    = pa_prev & ~pa_sync;
   assign wake_armed = wake_en & pa_dir & PA_GPIO_SEL;
   assign next_wake  = HALTED && (|(pa_fall & wake_armed));

   // Wake request: one-cycle pulse per detected edge
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         WAKE_REQ <= 1'b0;
      end else begin
         WAKE_REQ <= next_wake;
      end
   end

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   a_read_input_live: assert property (
      RD_STB && ADDR == gpio_pkg::IDX_PA_DATA && pa_dir == 8'hFF
      |=> RD_DATA == $past(pa_sync))
      else $error("port A input read does not show sampled pins");

   a_latch_holds: assert property (
      !(WR_STB && ADDR == gpio_pkg::IDX_PA_DATA) |=> $stable(pa_data) ##1 PA_OUT == $past(pa_data))
      else $error("port A latch or pad changed without a write");

   a_upper_bits_zero: assert property (
      RD_STB && (ADDR == gpio_pkg::IDX_PB_DATA || ADDR == gpio_pkg::IDX_PB_PU)
      |=> RD_DATA[7:4] == 4'h0)
      else $error("port B unimplemented bits not zero");

   a_pc_upper_zero: assert property (
      RD_STB && ADDR == gpio_pkg::IDX_PC_DIR |=> RD_DATA[7:2] == 6'h00)
      else $error("port C unimplemented bits not zero");

   a_pullup_write: assert property (
      WR_STB && ADDR == gpio_pkg::IDX_PA_PU |=> pa_pu == $past(WR_DATA))
      else $error("port A pull-high enable not stored");

   a_pullup_gated: assert property (
      ##1 (PA_PU & ~($past(pa_dir) | $past(PA_NMOS))) == 8'h00)
      else $error("pull-high on while pin drives as CMOS output");

   a_wake_cause: assert property (
      WAKE_REQ |-> $past(HALTED) && ($past(pa_fall & wake_en) != 8'h00))
      else $error("wake request without enabled falling edge while halted");

   a_wake_enable_w: assert property (
      WR_STB && ADDR == gpio_pkg::IDX_PA_WAKE |=> wake_en == $past(WR_DATA))
      else $error("wake enable not stored");

   a_wake_needs_halt: assert property (
      !HALTED |=> !WAKE_REQ)
      else $error("wake request while core running");

   a_output_reads_latch: assert property (
      RD_STB && ADDR == gpio_pkg::IDX_PB_DATA && pb_dir == 4'h0
      |=> RD_DATA[3:0] == $past(pb_data))
      else $error("output pin read does not return latch");

   a_cmos_drives: assert property (
      pa_dir == 8'h00 && PA_NMOS == 8'h00 |=> PA_OE_N == 8'h00)
      else $error("CMOS output pin not driven");

   // Pins reach the edge detector only after two flops
   a_sync_two_flops: assert property (
      !$past(RST, 2) |-> pa_sync == $past(PA_IN, 2))
      else $error("port A synchroniser is not two flops deep");

   // Read-back of narrow and unmapped places
   a_unmapped_zero: assert property (
      RD_STB && ADDR > gpio_pkg::IDX_PC_PU |=> RD_DATA == gpio_pkg::READ_UNMAPPED)
      else $error("unmapped register read not zero");

   a_pb_dir_upper: assert property (
      RD_STB && ADDR == gpio_pkg::IDX_PB_DIR |=> RD_DATA[7:4] == 4'h0)
      else $error("port B direction unimplemented bits not zero");

   a_pc_data_upper: assert property (
      RD_STB && (ADDR == gpio_pkg::IDX_PC_DATA || ADDR == gpio_pkg::IDX_PC_PU)
      |=> RD_DATA[7:2] == 6'h00)
      else $error("port C unimplemented bits not zero");

   // State right after reset release
   a_reset_inputs: assert property (
      $fell(RST) |-> PA_OE_N == 8'hFF && PB_OE_N == 4'hF && PC_OE_N == 2'h3)
      else $error("pins not all inputs after reset");

   a_reset_pullups: assert property (
      $fell(RST) |-> pa_pu == 8'h00 && pb_pu == 4'h0 && pc_pu == 2'h0)
      else $error("pull-high enables not cleared by reset");

   a_reset_wake: assert property (
      $fell(RST) |-> wake_en == 8'h00)
      else $error("wake enables not cleared by reset");

   a_input_floats: assert property (
      pa_dir == 8'hFF |=> PA_OE_N == 8'hFF)
      else $error("input pin is driven");

   a_pb_pullup_gated: assert property (
      ##1 (PB_PU & ~($past(pb_dir) | $past(PB_NMOS))) == 4'h0)
      else $error("port B pull-high on while pin drives as CMOS output");

   a_pb_pad_follows: assert property (
      WR_STB && ADDR == gpio_pkg::IDX_PB_DATA
      |=> ##1 PB_OUT == $past(WR_DATA[PB_W-1:0], 2))
      else $error("port B pad does not show written latch");

   a_wake_detect: assert property (
      HALTED && ((pa_prev & ~pa_sync & wake_en & pa_dir & PA_GPIO_SEL) != 8'h00)
      |=> WAKE_REQ)
      else $error("enabled falling edge while halted gave no wake");

   a_wake_gpio_only: assert property (
      (wake_en & pa_dir & PA_GPIO_SEL) == 8'h00 |=> !WAKE_REQ)
      else $error("wake request from a pin not armed as GPIO input");

   c_input_read: cover property (
      RD_STB && ADDR == gpio_pkg::IDX_PA_DATA ##1 RD_DATA != 8'hFF);
   c_wake: cover property (HALTED ##1 WAKE_REQ);
   c_open_drain_low: cover property (PA_NMOS[0] && !pa_dir[0] && !pa_data[0]);
   c_pullup_on: cover property (PB_PU != 4'h0);
endmodule

// file: tb/pin_model.sv
// Pin-side model: outside drivers, pad drive and pull-high on one port
module pin_model #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] pad_out,
   input  wire logic [W-1:0] pad_oe_n,
   input  wire logic [W-1:0] pad_pu,
   input  wire logic [W-1:0] ext_en,
   input  wire logic [W-1:0] ext_val,
   output logic      [W-1:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] flt = '0;
   // Undriven, unpulled pins wander so a stale level is never trusted
   always @(posedge clk) begin
      flt <= ~flt;
   end
   // Pad drive wins over the outside world, then pull-high, then noise
   assign pin = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
              | (pad_oe_n & ~ext_en & (pad_pu | flt));
endmodule

// file: tb/general_purpose_io_ports_tb_top.sv
// Self-checking bench for the general purpose port block
module general_purpose_io_ports_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] wdat = 8'h00;
   logic       halt = 1'b0;
   logic [7:0] gsel = 8'hFF;
   logic [7:0] an = 8'h00;
   logic [7:0] va = 8'hA5;
   logic [7:0] ext = 8'hFF;
   logic [7:0] rdat, ao, aoe, apu, ain;
   logic [3:0] bo, boe, bpu, bin;
   logic [1:0] co, coe, cpu, cin;
   logic       wake;
   int         err_count = 0;
   int         num_checks = 0;
   int         wakes = 0;
   int         cycles = 0;
   logic [7:0] expq[$];
   logic [3:0] cfg[8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hF};

   gpio_ports dut_u (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WR_STB(wr), .WR_DATA(wdat),
      .RD_STB(rd), .RD_DATA(rdat), .HALTED(halt), .PA_GPIO_SEL(gsel), .PA_NMOS(an),
      .PB_NMOS(an[3:0]), .PC_NMOS(an[1:0]), .PA_IN(ain), .PA_OUT(ao), .PA_OE_N(aoe),
      .PA_PU(apu), .PB_IN(bin), .PB_OUT(bo), .PB_OE_N(boe), .PB_PU(bpu), .PC_IN(cin),
      .PC_OUT(co), .PC_OE_N(coe), .PC_PU(cpu), .WAKE_REQ(wake));
   pin_model #(.W(8)) pa_u (.clk(clk), .pad_out(ao), .pad_oe_n(aoe), .pad_pu(apu),
      .ext_en(ext), .ext_val(va), .pin(ain));
   pin_model #(.W(4)) pb_u (.clk(clk), .pad_out(bo), .pad_oe_n(boe), .pad_pu(bpu),
      .ext_en(ext[3:0]), .ext_val(va[3:0]), .pin(bin));
   pin_model #(.W(2)) pc_u (.clk(clk), .pad_out(co), .pad_oe_n(coe), .pad_pu(cpu),
      .ext_en(ext[1:0]), .ext_val(va[1:0]), .pin(cin));

   always #2 clk = ~clk;

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Narrow ports keep only their low bits; unmapped places read zero
   function automatic logic [7:0] msk(input logic [3:0] a);
      if (a >= 4'h7 && a <= 4'h9) return 8'h03;
      if (a >= 4'h4 && a <= 4'h6) return 8'h0F;
      return (a <= 4'h3) ? 8'hFF : 8'h00;
   endfunction

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Expected read value is noted when the strobe goes out
   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      expq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // Read data lands on the edge that samples the strobe
   always @(posedge clk) begin
      if (rd === 1'b1) begin
         #1;
         check(rdat, expq.pop_front());
      end
   end

   always @(posedge clk) begin
      if (wake === 1'b1) wakes++;
   end

   // Hang guard, well beyond the roughly two hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      logic [7:0] v;
      logic [7:0] e;
      int         n;
      v = $urandom(63);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(aoe, 8'hFF);
      check(apu, 8'h00);
      check({4'h0, boe}, 8'h0F);
      check({6'h00, coe}, 8'h03);
      check({4'h0, bpu}, 8'h00);
      check({6'h00, cpu}, 8'h00);
      // Power-on contents; data places show the live pins
      for (int i = 0; i < 11; i++) begin
         e = (i == 0 || i == 4 || i == 7) ? va : (i == 1 || i == 5 || i == 8) ? 8'hFF : 8'h00;
         rreg(4'(i), e & msk(4'(i)));
      end
      // Configuration places hold what was written, unmapped ignores it
      foreach (cfg[k]) begin
         v = $urandom;
         wreg(cfg[k], v);
         rreg(cfg[k], v & msk(cfg[k]));
      end
      // Outputs: reads give the latch even against opposing pins
      v = $urandom;
      va <= ~v;
      wreg(4'h1, 8'h00);
      wreg(4'h5, 8'h00);
      wreg(4'h8, 8'h00);
      wreg(4'h0, v);
      wreg(4'h4, v);
      wreg(4'h7, v);
      for (int i = 0; i < 3; i++) begin
         rreg(4'(i == 0 ? 0 : 3 * i + 1), v & msk(4'(i == 0 ? 0 : 3 * i + 1)));
      end
      wreg(4'h6, 8'h0F);
      wreg(4'h9, 8'h03);
      wreg(4'h2, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      check(ao, v);
      check(bo, v[3:0]);
      check(co, v[1:0]);
      check(aoe, 8'h00);
      check({4'h0, boe}, 8'h00);
      check({6'h00, coe}, 8'h00);
      check({4'h0, bpu}, 8'h00);
      check({6'h00, cpu}, 8'h00);
      // Back to inputs: reads follow the live pins
      v = $urandom;
      va <= v;
      wreg(4'h1, 8'hFF);
      repeat (4) @(posedge clk);
      rreg(4'h0, v);
      // Pull-high only for inputs or open-drain outputs
      v = $urandom;
      wreg(4'h2, v);
      repeat (3) @(posedge clk);
      #1;
      check(apu, v);
      wreg(4'h1, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      check(apu, 8'h00);
      @(posedge clk);
      an <= 8'hFF;
      repeat (3) @(posedge clk);
      #1;
      check(apu, v);
      @(posedge clk);
      an <= 8'h00;
      wreg(4'h1, 8'hFF);
      // Released input pins rest on their pull-highs, not on noise
      wreg(4'h2, 8'hFF);
      @(posedge clk);
      ext <= 8'h00;
      repeat (4) @(posedge clk);
      rreg(4'h0, 8'hFF);
      va <= 8'hFF;
      ext <= 8'hFF;
      // Wake cases: armed, not halted, shared function, disabled
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         halt <= (k != 1);
         gsel <= (k == 2) ? 8'h00 : 8'hFF;
         va <= 8'hFF;
         wreg(4'h3, (k == 3) ? 8'h00 : 8'h01);
         repeat (4) @(posedge clk);
         n = wakes;
         va <= 8'hFE;
         repeat (6) @(posedge clk);
         check(8'(wakes - n), {7'h00, k == 0});
      end
      repeat (3) @(posedge clk);
      end_sim();
   end
endmodule
